// [ssp_cfg.svh]
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// register indices; byte address is four times the index
`define SSP_IDX_DATA      12'h18C
`define SSP_IDX_DIV       12'h18D
`define SSP_IDX_MASK      12'h18E
`define SSP_IDX_STAT      12'h18F
`define SSP_IDX_CTRL      12'h190

// reset values
`define SSP_RST_DATA      8'h00
`define SSP_RST_DIV       8'h00
`define SSP_RST_MASK      8'hFF
`define SSP_RST_STAT      8'h00
`define SSP_RST_CTRL      8'h00

// status field positions
`define SSP_ST_SMP        7
`define SSP_ST_CKE        6
`define SSP_ST_DA         5
`define SSP_ST_STOP       4
`define SSP_ST_START      3
`define SSP_ST_RW         2
`define SSP_ST_UA         1
`define SSP_ST_BF         0

// control field positions
`define SSP_CT_EN         5
`define SSP_CT_MODE_HI    3
`define SSP_CT_MODE_LO    0

// serial clock period is (n+1) times this many system clocks
`define SSP_OSC_PER_TICK  4
`define SSP_MIN_DIV       8'h03

`endif

// [ssp_pkg.sv]
`default_nettype none

package ssp_pkg;

  // operating mode, as held in the control register
  typedef enum logic [3:0] {
    SSP_SPI_HOST_0   = 4'h0,
    SSP_SPI_HOST_1   = 4'h1,
    SSP_SPI_HOST_2   = 4'h2,
    SSP_SPI_HOST_3   = 4'h3,
    SSP_SPI_CLIENT_0 = 4'h4,
    SSP_SPI_CLIENT_1 = 4'h5,
    SSP_I2C_HOST     = 4'h8,
    SSP_SPI_HOST_DIV = 4'hA,
    SSP_I2C_FW_HOST  = 4'hB,
    SSP_I2C_CL_7B    = 4'hE,
    SSP_I2C_CL_10B   = 4'hF
  } ssp_mode_t;

  // bus slave handshake phase
  typedef enum logic [1:0] {
    SSP_BUS_IDLE = 2'b01,
    SSP_BUS_ACK  = 2'b10
  } ssp_bus_t;

endpackage : ssp_pkg

`default_nettype wire

// [ssp_regs.sv]
`include "ssp_cfg.svh"
`default_nettype none

// Overview of operation
// - one 8-bit read/write buffer holds both outgoing and received byte
// - host modes: serial clock period is (n+1) times 4 system clocks
// - 10-bit client high phase: register bits 2:1 give address bits 9:8
// - 10-bit client low phase: all register bits give address bits 7:0
// - 7-bit client: register bits 7:1 are own address, bit 0 ignored
// - client: mask bits 7:1 set compare, cleared exclude that address bit
// - mask bit 0 applies to address bit 0 only in 10-bit client mode
// - spi host: sample phase 1 samples at end, 0 at middle
// - i2c: sample phase 1 disables slew control, 0 enables it
// - spi: edge select 1 shifts on active-to-idle, 0 on idle-to-active
// - i2c: edge select 1 picks smbus input levels, 0 normal levels
// - i2c client: data/address flag 1 after data byte, 0 after address
// - i2c: stop flag set when last condition seen was a stop
// - i2c: start flag set when last condition seen was a start
// - i2c client: direction flag 1 for read, 0 for write
// - i2c host: direction flag 1 while transmit in progress
// - address refresh flag has meaning only in 10-bit client mode
// - 10-bit client: refresh flag asks software to reload own address
// - buffer full set on transmit or completed receive, cleared after
// - start and stop flags clear on reset and when port disabled
// - client direction holds from address match until start, stop, nack
module ssp_regs (
  input  wire logic        i_clock,          // system clock
  input  wire logic        i_rst_n,          // async reset, active low
  // avalon-mm slave
  input  wire logic [11:0] i_avs_address,    // byte address
  input  wire logic        i_avs_read,       // read strobe
  input  wire logic        i_avs_write,      // write strobe
  input  wire logic [31:0] i_avs_writedata,  // write data
  input  wire logic [3:0]  i_avs_byteenable, // byte lanes
  output logic      [31:0] o_avs_readdata,   // read data
  output logic             o_avs_waitrequest,// stall
  // events from the serial engine
  input  wire logic        i_start_det,      // start condition seen
  input  wire logic        i_stop_det,       // stop condition seen
  input  wire logic        i_nack_det,       // not-ack bit seen
  input  wire logic        i_addr_byte,      // address byte done
  input  wire logic        i_data_byte,      // data byte done
  input  wire logic [7:0]  i_rx_addr,        // received address byte
  input  wire logic        i_addr_high,      // 10-bit high phase active
  input  wire logic        i_rx_done,        // receive complete
  input  wire logic [7:0]  i_rx_byte,        // received byte
  input  wire logic        i_tx_done,        // transmit complete
  input  wire logic        i_host_busy,      // host transmit running
  input  wire logic        i_addr_reload,    // engine wants new address
  // controls to the serial engine and pads
  output logic             o_port_enable,    // port enabled
  output logic      [3:0]  o_mode,           // mode select
  output logic      [7:0]  o_tx_byte,        // byte to shift out
  output logic             o_tx_start,       // buffer written, pulse
  output logic             o_serial_clk,     // host serial clock
  output logic             o_addr_match,     // client address match
  output logic             o_sample_at_end,  // spi host late sample
  output logic             o_tx_active_idle, // spi shift edge select
  output logic             o_slew_ctl_en,    // i2c pad slew control
  output logic             o_smbus_levels    // i2c smbus thresholds
);

  // masked equality, used for every phase of the address compare
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    masked_eq = (((a ^ b) & m) == 8'h00);
  endfunction : masked_eq

  // decode of a byte address to a register index hit
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr == {idx[9:0], 2'b00});
  endfunction : hit

  // register and handshake state
  ssp_pkg::ssp_bus_t bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  data_q, data_d;
  logic [7:0]  div_q, div_d;
  logic [7:0]  mask_q, mask_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic        smp_q, smp_d;
  logic        cke_q, cke_d;
  logic        da_q, da_d;
  logic        stop_q, stop_d;
  logic        start_q, start_d;
  logic        rw_q, rw_d;
  logic        ua_q, ua_d;
  logic        bf_q, bf_d;
  logic        txs_q, txs_d;
  logic [7:0]  brg_q, brg_d;
  logic        pre_q, pre_d;
  logic        sclk_q, sclk_d;

  // mode decode
  ssp_pkg::ssp_mode_t mode;
  logic spi_host;
  logic spi_mode;
  logic i2c_host;
  logic i2c_client;
  logic i2c_mode;
  logic ten_bit;
  logic enable;

  assign mode       = ssp_pkg::ssp_mode_t'(ctrl_q[`SSP_CT_MODE_HI:`SSP_CT_MODE_LO]);
  assign enable     = ctrl_q[`SSP_CT_EN];
  assign spi_host   = (ctrl_q[3:2] == 2'b00) || (mode == ssp_pkg::SSP_SPI_HOST_DIV);
  assign spi_mode   = spi_host || (mode == ssp_pkg::SSP_SPI_CLIENT_0) ||
                      (mode == ssp_pkg::SSP_SPI_CLIENT_1);
  assign i2c_host   = (mode == ssp_pkg::SSP_I2C_HOST) || (mode == ssp_pkg::SSP_I2C_FW_HOST);
  assign ten_bit    = (mode == ssp_pkg::SSP_I2C_CL_10B);
  assign i2c_client = ten_bit || (mode == ssp_pkg::SSP_I2C_CL_7B);
  assign i2c_mode   = i2c_host || i2c_client;

  // bus access qualifiers; a write lands only on the acknowledge edge
  logic req;
  logic acc;
  logic wr;
  logic rd;
  assign req = i_avs_read || i_avs_write;
  assign acc = req && (bus_q == ssp_pkg::SSP_BUS_ACK);
  assign wr  = acc && i_avs_write && i_avs_byteenable[0];
  assign rd  = acc && i_avs_read;
  assign o_avs_waitrequest = req && (bus_q != ssp_pkg::SSP_BUS_ACK);

  // one wait cycle per access; read data captured then so it stands at the ack
  always_comb
  begin
    bus_d   = ssp_pkg::SSP_BUS_IDLE;
    rdata_d = rdata_q;
    case (bus_q)
      ssp_pkg::SSP_BUS_IDLE:
      begin
        if (req)
        begin
          bus_d   = ssp_pkg::SSP_BUS_ACK;
          rdata_d = 32'h0000_0000; // unmapped reads return zero
          if (hit(i_avs_address, `SSP_IDX_DATA))
            rdata_d[7:0] = data_q;
          else if (hit(i_avs_address, `SSP_IDX_DIV))
            rdata_d[7:0] = div_q;
          else if (hit(i_avs_address, `SSP_IDX_MASK))
            rdata_d[7:0] = mask_q;
          else if (hit(i_avs_address, `SSP_IDX_STAT))
            rdata_d[7:0] = {smp_q, cke_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q};
          else if (hit(i_avs_address, `SSP_IDX_CTRL))
            rdata_d[7:0] = ctrl_q;
        end
      end
      ssp_pkg::SSP_BUS_ACK:
        bus_d = ssp_pkg::SSP_BUS_IDLE;
      default:
        bus_d = ssp_pkg::SSP_BUS_IDLE;
    endcase
  end

  // software-written registers; unmapped writes fall through untouched
  always_comb
  begin
    div_d  = div_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    smp_d  = smp_q;
    cke_d  = cke_q;
    if (wr && hit(i_avs_address, `SSP_IDX_DIV))
      div_d = i_avs_writedata[7:0];
    if (wr && hit(i_avs_address, `SSP_IDX_MASK))
      mask_d = i_avs_writedata[7:0];
    if (wr && hit(i_avs_address, `SSP_IDX_CTRL))
      ctrl_d = i_avs_writedata[7:0];
    if (wr && hit(i_avs_address, `SSP_IDX_STAT))
    begin
      // only the two select bits are writable here
      smp_d = i_avs_writedata[`SSP_ST_SMP];
      cke_d = i_avs_writedata[`SSP_ST_CKE];
    end
  end

  // shared data byte: software write loads the outgoing byte, receive the incoming
  always_comb
  begin
    data_d = data_q;
    txs_d  = 1'b0;
    if (wr && hit(i_avs_address, `SSP_IDX_DATA))
    begin
      data_d = i_avs_writedata[7:0];
      txs_d  = enable;
    end
    else if (i_rx_done && enable)
      data_d = i_rx_byte;
  end

  // buffer full: setting events beat the clearing ones in the same cycle
  always_comb
  begin
    bf_d = bf_q;
    if (!enable)
      bf_d = 1'b0;
    else if (txs_d || i_rx_done)
      bf_d = 1'b1;
    else if (i_tx_done || (rd && hit(i_avs_address, `SSP_IDX_DATA)))
      bf_d = 1'b0;
  end

  // bus condition flags; only the latest condition is shown
  always_comb
  begin
    start_d = start_q;
    stop_d  = stop_q;
    if (!enable)
    begin
      start_d = 1'b0;
      stop_d  = 1'b0;
    end
    else if (i2c_mode && i_stop_det)
    begin
      stop_d  = 1'b1;
      start_d = 1'b0;
    end
    else if (i2c_mode && i_start_det)
    begin
      start_d = 1'b1;
      stop_d  = 1'b0;
    end
  end

  // data/address kind of the last byte in client mode
  always_comb
  begin
    da_d = da_q;
    if (!enable)
      da_d = 1'b0;
    else if (i2c_client && i_data_byte)
      da_d = 1'b1;
    else if (i2c_client && i_addr_byte)
      da_d = 1'b0;
  end

  // direction: client latches r/w on match, host shows transmit activity
  always_comb
  begin
    rw_d = rw_q;
    if (!enable)
      rw_d = 1'b0;
    else if (i2c_host)
      rw_d = i_host_busy;
    else if (i2c_client && i_addr_byte && o_addr_match && !i_addr_high)
      rw_d = i_rx_addr[0];
    else if (i2c_client && (i_start_det || i_stop_det || i_nack_det))
      rw_d = 1'b0;
  end

  // address refresh request; a write to the divider register satisfies it
  always_comb
  begin
    ua_d = ua_q;
    if (!enable || !ten_bit)
      ua_d = 1'b0;
    else if (i_addr_reload)
      ua_d = 1'b1;
    else if (wr && hit(i_avs_address, `SSP_IDX_DIV))
      ua_d = 1'b0;
  end

  // address compare in the three client phases
  always_comb
  begin
    o_addr_match = 1'b0;
    if (i2c_client && enable)
    begin
      if (!ten_bit)
        // bit 0 carries r/w, so it never takes part
        o_addr_match = masked_eq(i_rx_addr, div_q, {mask_q[7:1], 1'b0});
      else if (i_addr_high)
        o_addr_match = masked_eq(i_rx_addr, div_q, {5'h00, mask_q[2:1], 1'b0});
      else
        o_addr_match = masked_eq(i_rx_addr, div_q, mask_q);
    end
  end

  // baud generator: half period is 2*(n+1) clocks, so full period is 4*(n+1)
  // divider values below the minimum are not trapped; software keeps n >= 3
  logic brg_run;
  assign brg_run = enable && (spi_host || i2c_host) && (i_host_busy || bf_q);

  always_comb
  begin
    brg_d  = brg_q;
    pre_d  = 1'b0;
    sclk_d = sclk_q;
    if (!brg_run)
    begin
      brg_d  = div_q;
      sclk_d = 1'b0;
    end
    else
    begin
      pre_d = ~pre_q; // prescale by two
      if (pre_q)
      begin
        if (brg_q == 8'h00)
        begin
          brg_d  = div_q;
          sclk_d = ~sclk_q;
        end
        else
          brg_d = brg_q - 8'h01;
      end
    end
  end

  // pad and sampling selects
  assign o_sample_at_end  = enable && spi_host && smp_q;
  assign o_tx_active_idle = spi_mode && cke_q;
  assign o_slew_ctl_en    = i2c_mode && !smp_q;
  assign o_smbus_levels   = i2c_mode && cke_q;
  assign o_port_enable    = enable;
  assign o_mode           = ctrl_q[`SSP_CT_MODE_HI:`SSP_CT_MODE_LO];
  assign o_tx_byte        = data_q;
  assign o_tx_start       = txs_q;
  assign o_serial_clk     = sclk_q;
  assign o_avs_readdata   = rdata_q;

  // state registers
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_q   <= ssp_pkg::SSP_BUS_IDLE;
      rdata_q <= 32'h0000_0000;
      data_q  <= `SSP_RST_DATA;
      div_q   <= `SSP_RST_DIV;
      mask_q  <= `SSP_RST_MASK;
      ctrl_q  <= `SSP_RST_CTRL;
      smp_q   <= 1'b0;
      cke_q   <= 1'b0;
      da_q    <= 1'b0;
      stop_q  <= 1'b0;
      start_q <= 1'b0;
      rw_q    <= 1'b0;
      ua_q    <= 1'b0;
      bf_q    <= 1'b0;
      txs_q   <= 1'b0;
      brg_q   <= 8'h00;
      pre_q   <= 1'b0;
      sclk_q  <= 1'b0;
    end
    else
    begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
      data_q  <= data_d;
      div_q   <= div_d;
      mask_q  <= mask_d;
      ctrl_q  <= ctrl_d;
      smp_q   <= smp_d;
      cke_q   <= cke_d;
      da_q    <= da_d;
      stop_q  <= stop_d;
      start_q <= start_d;
      rw_q    <= rw_d;
      ua_q    <= ua_d;
      bf_q    <= bf_d;
      txs_q   <= txs_d;
      brg_q   <= brg_d;
      pre_q   <= pre_d;
      sclk_q  <= sclk_d;
    end
  end

endmodule : ssp_regs

`default_nettype wire

// [ssp_regs_sva.sv]
`default_nettype none
module ssp_regs_chk (
  input wire logic        i_clock,           // clock
  input wire logic        i_rst_n,           // reset
  input wire logic [11:0] i_avs_address,     // address
  input wire logic        i_avs_write,       // write
  input wire logic [31:0] i_avs_writedata,   // data
  input wire logic [3:0]  i_avs_byteenable,  // lanes
  input wire logic        o_avs_waitrequest, // stall
  input wire logic [7:0]  i_rx_addr,         // rx address
  input wire logic        i_addr_high,       // high phase
  input wire logic        o_port_enable,     // enable
  input wire logic [3:0]  o_mode,            // mode
  input wire logic [7:0]  o_tx_byte,         // tx byte
  input wire logic        o_tx_start,        // tx pulse
  input wire logic        o_serial_clk,      // baud
  input wire logic        o_addr_match,      // match
  input wire logic        o_sample_at_end,   // late sample
  input wire logic        o_tx_active_idle,  // edge
  input wire logic        o_slew_ctl_en,     // slew
  input wire logic        o_smbus_levels     // smbus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_q, div_d, msk_q, msk_d, wd;
  logic [8:0] cnt_q, cnt_d;
  logic       smp_q, smp_d, cke_q, cke_d, clk_q, wr_ok, spi, i2c;
  // a write lands only at the edge where the stall is low
  assign wd = i_avs_writedata[7:0];
  assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign spi = o_port_enable && (o_mode <= 4'h5 || o_mode == 4'hA);
  assign i2c = o_port_enable && (o_mode == 4'h8 || o_mode == 4'hB || o_mode >= 4'hE);
  // shadow fields; count since baud clock last moved, saturating
  always_comb
  begin
    div_d = (wr_ok && i_avs_address == 12'h634) ? wd : div_q;
    msk_d = (wr_ok && i_avs_address == 12'h638) ? wd : msk_q;
    smp_d = (wr_ok && i_avs_address == 12'h63C) ? wd[7] : smp_q;
    cke_d = (wr_ok && i_avs_address == 12'h63C) ? wd[6] : cke_q;
    cnt_d = (o_serial_clk != clk_q) ? 9'h001 : cnt_q + {8'h00, cnt_q != 9'h1FF};
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {div_q, msk_q, smp_q, cke_q, clk_q, cnt_q} <= {8'h00, 8'hFF, 3'h0, 9'h000};
    else
      {div_q, msk_q, smp_q, cke_q, clk_q, cnt_q} <= {div_d, msk_d, smp_d, cke_d, o_serial_clk, cnt_d};
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  chk_baud_half: assert property ($fell(o_serial_clk) |-> cnt_q == {div_q, 1'b0} + 9'h002)
    else $error("baud half period wrong");
  chk_sample_end: assert property (spi && o_mode != 4'h4 && o_mode != 4'h5 |-> o_sample_at_end == smp_q)
    else $error("sample phase wrong");
  chk_slew_sel: assert property (i2c |-> o_slew_ctl_en == !smp_q)
    else $error("slew select wrong");
  chk_shift_edge: assert property (spi |-> o_tx_active_idle == cke_q)
    else $error("shift edge wrong");
  chk_smbus_sel: assert property (i2c |-> o_smbus_levels == cke_q)
    else $error("input levels wrong");
  chk_match_7b: assert property (o_port_enable && o_mode == 4'hE |->
    o_addr_match == (((i_rx_addr ^ div_q) & msk_q & 8'hFE) == 8'h00)) else $error("7-bit match wrong");
  chk_match_10b: assert property (o_port_enable && o_mode == 4'hF |->
    o_addr_match == (((i_rx_addr ^ div_q) & msk_q & (i_addr_high ? 8'h06 : 8'hFF)) == 8'h00))
    else $error("10-bit match wrong");
  chk_tx_launch: assert property (wr_ok && i_avs_address == 12'h630 && o_port_enable |=>
    o_tx_start && o_tx_byte == $past(wd) ##1 !o_tx_start) else $error("transmit launch wrong");
  cov_baud: cover property ($fell(o_serial_clk));
  cov_match_hi: cover property (o_addr_match && i_addr_high && o_mode == 4'hF);
  cov_launch: cover property (o_tx_start);
endmodule : ssp_regs_chk
bind ssp_regs ssp_regs_chk u_chk (.*);
`default_nettype wire

// [ssp_engine_model.sv]
`default_nettype none
module ssp_engine_model (
  input  wire logic       i_clock,    // clock
  input  wire logic       i_tx_start, // buffer loaded
  input  wire logic [6:0] i_ev,       // event strobes to raise
  input  wire logic [7:0] i_addr_set, // address byte to present
  input  wire logic [7:0] i_byte_set, // data byte to present
  input  wire logic       i_busy_set, // host transfer running
  input  wire logic       i_high_set, // 10-bit high phase
  output wire logic       o_start,    // start seen
  output wire logic       o_stop,     // stop seen
  output wire logic       o_nack,     // nack seen
  output wire logic       o_addr_b,   // address byte
  output wire logic       o_data_b,   // data byte
  output wire logic       o_rx_done,  // byte received
  output wire logic       o_reload,   // reload request
  output wire logic       o_tx_done,  // byte sent
  output wire logic       o_busy,     // host busy
  output wire logic       o_high,     // high phase
  output wire logic [7:0] o_rx_addr,  // rx address
  output wire logic [7:0] o_rx_byte   // rx byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       txd_q = 1'b0;
  int         tx_lat = 30;
  // strobes pass through as the bench raises them, one cycle each
  assign {o_reload, o_rx_done, o_data_b, o_addr_b, o_nack, o_stop, o_start} = i_ev;
  assign {o_tx_done, o_busy, o_high, o_rx_addr} = {txd_q, i_busy_set, i_high_set, i_addr_set};
  // byte lines are scrambled outside the strobe, so a late load shows
  assign o_rx_byte = o_rx_done ? i_byte_set : ~i_byte_set;
  // a slow transmit: done long after the buffer loads
  always @(posedge i_clock)
  begin
    if (i_tx_start === 1'b1)
    begin
      repeat (tx_lat) @(posedge i_clock);
      txd_q <= 1'b1;
      @(posedge i_clock);
      txd_q <= 1'b0;
    end
  end
endmodule : ssp_engine_model
`default_nettype wire

// [ssp_regs_test.sv]
`default_nettype none
module ssp_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0;
  logic        i_rst_n, i_avs_read, i_avs_write;
  logic [11:0] i_avs_address;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable, be_sel;
  logic [7:0]  q, cm;
  logic [7:0]  ra = 8'h00, rb = 8'h00;
  logic [6:0]  ev = 7'h00;
  logic        bz = 1'b0, hi = 1'b0;
  wire logic [31:0] o_avs_readdata;
  wire logic [7:0]  i_rx_addr, i_rx_byte, o_tx_byte;
  wire logic [3:0]  o_mode;
  wire logic o_avs_waitrequest, i_start_det, i_stop_det, i_nack_det, i_addr_byte, i_data_byte, i_addr_high;
  wire logic i_rx_done, i_tx_done, i_host_busy, i_addr_reload, o_port_enable, o_tx_start, o_serial_clk;
  wire logic o_addr_match, o_sample_at_end, o_tx_active_idle, o_slew_ctl_en, o_smbus_levels;
  int err_total = 0;
  int tests_run = 0;
  int n;
  always #2 i_clock = ~i_clock;
  ssp_regs uut (.*);
  ssp_engine_model eng (.i_clock(i_clock), .i_tx_start(o_tx_start), .i_ev(ev), .i_addr_set(ra), .i_byte_set(rb),
    .i_busy_set(bz), .i_high_set(hi), .o_start(i_start_det), .o_stop(i_stop_det),
    .o_nack(i_nack_det), .o_addr_b(i_addr_byte), .o_data_b(i_data_byte), .o_rx_done(i_rx_done),
    .o_reload(i_addr_reload), .o_tx_done(i_tx_done), .o_busy(i_host_busy), .o_high(i_addr_high),
    .o_rx_addr(i_rx_addr), .o_rx_byte(i_rx_byte));
  task give_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until the edge that sees the stall low
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_byteenable <= be_sel;
    @(posedge i_clock);
    while (o_avs_waitrequest !== 1'b0)
    begin
      k++;
      if (k > 20)
      begin
        err_total++;
        $display("mismatch at %0t: bus timeout", $time);
        give_verdict();
      end
      @(posedge i_clock);
    end
    q = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rc(input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rc
  // one-cycle event strobe from the far side
  task pulse(input logic [6:0] m);
    @(posedge i_clock);
    ev <= m;
    @(posedge i_clock);
    ev <= 7'h00;
  endtask : pulse
  task mt(input logic [7:0] c, a, m, r, input logic h, x);
    wr(12'h640, c);
    wr(12'h634, a);
    wr(12'h638, m);
    ra <= r;
    hi <= h;
    repeat (2) @(posedge i_clock);
    chk({7'h00, o_addr_match}, {7'h00, x});
  endtask : mt
  // cycles the baud clock stays at one level, bounded
  task span(input logic lvl);
    n = 0;
    while (o_serial_clk === lvl && n < 99)
    begin
      @(posedge i_clock);
      n++;
    end
    if (n == 99)
    begin
      err_total++;
      $display("mismatch at %0t: baud clock stuck", $time);
      give_verdict();
    end
  endtask : span
  initial
  begin
    {i_rst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = 47'h0;
    i_avs_byteenable = 4'hF;
    be_sel = 4'hF;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rc(12'h630, 8'h00);
    rc(12'h634, 8'h00);
    rc(12'h638, 8'hFF);
    rc(12'h63C, 8'h00);
    rc(12'h644, 8'h00);
    wr(12'h630, 8'hA5);
    rc(12'h630, 8'hA5);
    wr(12'h63C, 8'hFF);
    rc(12'h63C, 8'hC0);
    be_sel = 4'hE;
    wr(12'h638, 8'h00);
    be_sel = 4'hF;
    rc(12'h638, 8'hFF);
    wr(12'h644, 8'h55);
    rc(12'h644, 8'h00);
    // every phase/edge combination for spi host mode A and both i2c host modes; spi host modes 0-3 get one each
    for (int i = 0; i < 16; i++)
    begin
      cm = i[3] ? (i[2] ? 8'h2B : 8'h28) : (i[2] ? 8'h2A : {6'h08, i[1:0]});
      wr(12'h640, cm);
      wr(12'h63C, {i[1:0], 6'h00});
      @(posedge i_clock);
      chk({3'h0, o_port_enable, o_mode}, {4'h1, cm[3:0]});
      if (i[3])
      begin
        chk({7'h00, o_slew_ctl_en}, {7'h00, !i[1]});
        chk({7'h00, o_smbus_levels}, {7'h00, i[0]});
      end
      else
      begin
        chk({7'h00, o_sample_at_end}, {7'h00, i[1]});
        chk({7'h00, o_tx_active_idle}, {7'h00, i[0]});
      end
    end
    wr(12'h63C, 8'h00);
    wr(12'h634, 8'h03);
    bz <= 1'b1;
    rc(12'h63C, 8'h04);
    span(1'b0);
    span(1'b1);
    chk(n[7:0], 8'h08);
    span(1'b0);
    chk(n[7:0], 8'h08);
    span(1'b1);
    bz <= 1'b0;
    rc(12'h63C, 8'h00);
    // i2c 7-bit client event sequence, then 10-bit address refresh and client address matches
    wr(12'h640, 8'h2E);
    wr(12'h634, 8'hA4);
    pulse(7'h01);
    rc(12'h63C, 8'h08);
    ra <= 8'hB5;
    pulse(7'h08);
    rc(12'h63C, 8'h08);
    ra <= 8'hA5;
    pulse(7'h08);
    rc(12'h63C, 8'h0C);
    pulse(7'h10);
    rc(12'h63C, 8'h2C);
    pulse(7'h04);
    rc(12'h63C, 8'h28);
    rb <= 8'h77;
    pulse(7'h20);
    rc(12'h63C, 8'h29);
    rc(12'h630, 8'h77);
    ra <= 8'hA4;
    pulse(7'h08);
    rc(12'h63C, 8'h08);
    pulse(7'h42);
    rc(12'h63C, 8'h10);
    wr(12'h640, 8'h0E);
    pulse(7'h01);
    rc(12'h63C, 8'h00);
    wr(12'h640, 8'h2F);
    pulse(7'h40);
    rc(12'h63C, 8'h02);
    wr(12'h634, 8'h34);
    rc(12'h63C, 8'h00);
    mt(8'h2E, 8'hA4, 8'hFF, 8'hA5, 1'b0, 1'b1);
    mt(8'h2E, 8'hA4, 8'hFF, 8'hA6, 1'b0, 1'b0);
    mt(8'h2E, 8'hA4, 8'hFD, 8'hA6, 1'b0, 1'b1);
    mt(8'h2F, 8'h34, 8'hFF, 8'h35, 1'b0, 1'b0);
    mt(8'h2F, 8'h34, 8'hFE, 8'h35, 1'b0, 1'b1);
    mt(8'h2F, 8'hF2, 8'hFF, 8'h0B, 1'b1, 1'b1);
    mt(8'h2F, 8'hF2, 8'hFF, 8'h04, 1'b1, 1'b0);
    // spi client transmit against a slow far side
    wr(12'h640, 8'h24);
    wr(12'h630, 8'h3C);
    // the data register loads at the acknowledge edge; look one edge later
    @(posedge i_clock);
    chk(o_tx_byte, 8'h3C);
    rc(12'h63C, 8'h01);
    repeat (40) @(posedge i_clock);
    rc(12'h63C, 8'h00);
    give_verdict();
  end
endmodule : ssp_regs_test
`default_nettype wire
